// *** basic_trigger_and_key_lockout.sv ***
/*
  Basic trigger control and front-panel key lockout with a register port.
  Assumes a 25 MHz clock, a synchronous active-low reset, register accesses
  tagged with the host port they came from, and a measurement engine that
  raises reading_busy_i while a reading is in progress.
*/
`timescale 1ns/10ps
`include "panel_trigger_key_lock_regs.svh"

module basic_trigger_and_key_lockout #(
  parameter int MS_CYCLES = `TIME_MS_NS / `CLK_PERIOD_NS
) (
  input  wire logic               clk_i,
  input  wire logic               rst_n_i,
  input  wire logic [`ADDR_W-1:0] addr_i,
  input  wire logic [31:0]        wdata_i,
  input  wire logic               wr_i,
  input  wire logic               rd_i,
  input  wire logic               serial_port_i,
  output logic [31:0]             rdata_o,
  input  wire logic               bus_get_i,
  input  wire logic               advanced_select_i,
  input  wire logic               panel_trigger_key_i,
  input  wire logic               rear_trigger_input_i,
  input  wire logic [`KEYS_W-1:0] panel_keys_i,
  input  wire logic               reading_busy_i,
  output logic                    reading_start_o,
  output logic [`KEYS_W-1:0]      panel_keys_o,
  output logic                    host_ctrl_o,
  output logic                    key_lockout_flag_o,
  output logic                    basic_active_o
);

  panel_trigger_key_lock_pkg::ctrl_state_s s;
  panel_trigger_key_lock_pkg::ctrl_state_s next_s;

  timer_if tmr ();

  interval_timer #(
    .MS_CYCLES (MS_CYCLES)
  ) u_timer (
    .clk_i   (clk_i),
    .rst_n_i (rst_n_i),
    .tmr     (tmr)
  );

  function automatic logic hit(input logic         strobe,
                               input logic [`ADDR_W-1:0] a,
                               input logic [`ADDR_W-1:0] target);
    hit = strobe && (a == target);
  endfunction

  function automatic logic src_ok(input logic [2:0] code);
    src_ok = (code <= panel_trigger_key_lock_pkg::SRC_TIMER);
  endfunction

  logic                 cmd_wr;
  logic                 lock_wr;
  logic                 panel_trigger_key_wr;
  logic                 ivl_wr;
  logic                 host_cmd;
  logic                 panel_cmd;
  logic                 lock_bit;
  logic                 key_rise;
  logic                 rear_rise;
  logic                 ev;
  logic                 keys_ok;
  logic                 pend;
  logic [2:0]           new_src;
  logic [`IVL_W-1:0]    new_ivl;

  assign cmd_wr    = hit(wr_i, addr_i, `ADDR_CMD);
  assign lock_wr   = hit(wr_i, addr_i, `ADDR_LOCK);
  assign panel_trigger_key_wr   = hit(wr_i, addr_i, `ADDR_PANEL_TRIGGER_KEY);
  assign ivl_wr    = hit(wr_i, addr_i, `ADDR_IVL);
  // host and panel mode changes come only from the serial port, like the lockout itself
  assign host_cmd  = cmd_wr && serial_port_i && wdata_i[`CMD_HOST_BIT];
  assign panel_cmd = cmd_wr && serial_port_i && wdata_i[`CMD_PANEL_BIT];
  assign lock_bit  = wdata_i[`LOCK_FLAG_BIT];
  assign new_src   = wdata_i[`PANEL_TRIGGER_KEY_SRC_MSB:`PANEL_TRIGGER_KEY_SRC_LSB];
  assign new_ivl   = wdata_i[`IVL_W-1:0];

  // only sync2 and prev feed edge detection; sync1 is read by sync2 alone
  assign key_rise  = s.sync2[0] && !s.prev[0] && !s.host_ctrl;
  assign rear_rise = s.sync2[1] && !s.prev[1];
  assign keys_ok   = !(s.host_ctrl && s.lockout);

  always_comb begin
    case (s.src)
      panel_trigger_key_lock_pkg::SRC_FREE:  ev = 1'b1;
      panel_trigger_key_lock_pkg::SRC_KEY:   ev = key_rise;
      panel_trigger_key_lock_pkg::SRC_BUS:   ev = s.bus_trg || bus_get_i;
      panel_trigger_key_lock_pkg::SRC_REAR:  ev = rear_rise;
      panel_trigger_key_lock_pkg::SRC_TIMER: ev = tmr.expire;
      default:                  ev = 1'b0;
    endcase
  end

  // an event landing while a reading runs is held, the clear on a start winning over a new event
  assign pend = s.pending || ev;

  always_comb begin
    next_s         = s;
    next_s.start   = 1'b0;
    next_s.bus_trg = 1'b0;
    next_s.restart = 1'b0;
    next_s.sync1   = {panel_keys_i, rear_trigger_input_i, panel_trigger_key_i};
    next_s.sync2   = s.sync1;
    next_s.prev    = s.sync2[1:0];
    next_s.keys    = keys_ok ? s.sync2[`KEYS_W+1:2] : '0;

    if (host_cmd && !panel_cmd) begin
      next_s.host_ctrl = 1'b1;
    end else if (panel_cmd) begin
      next_s.host_ctrl = 1'b0;
    end

    if (lock_wr && serial_port_i && s.host_ctrl) begin
      next_s.lockout = lock_bit;
    end

    if (cmd_wr && wdata_i[`CMD_BUSTRG_BIT]) begin
      next_s.bus_trg = 1'b1;
    end

    if (panel_trigger_key_wr && src_ok(new_src)) begin
      next_s.src     = panel_trigger_key_lock_pkg::panel_trigger_key_src_e'(new_src);
      next_s.single  = wdata_i[`PANEL_TRIGGER_KEY_SINGLE_BIT];
      next_s.restart = (new_src == panel_trigger_key_lock_pkg::SRC_TIMER) &&
                       (s.src != panel_trigger_key_lock_pkg::SRC_TIMER);
    end

    // out-of-range intervals are dropped so the timer never sees zero
    if (ivl_wr && new_ivl >= `IVL_MIN && new_ivl <= `IVL_MAX) begin
      next_s.interval = new_ivl;
      next_s.restart  = 1'b1;
    end

    if (!s.basic) begin
      next_s.run     = panel_trigger_key_lock_pkg::RUN_IDLE;
      next_s.pending = 1'b0;
    end else if (panel_trigger_key_wr) begin
      // a new mode or source starts from a quiet state
      next_s.run     = panel_trigger_key_lock_pkg::RUN_IDLE;
      next_s.pending = 1'b0;
    end else if (s.single) begin
      next_s.run = panel_trigger_key_lock_pkg::RUN_IDLE;
      if (pend && !reading_busy_i) begin
        next_s.start   = 1'b1;
        next_s.pending = 1'b0;
      end else begin
        next_s.pending = pend;
      end
    end else begin
      next_s.pending = 1'b0;
      if (ev) begin
        next_s.run = panel_trigger_key_lock_pkg::RUN_CONT;
      end
      if ((s.run == panel_trigger_key_lock_pkg::RUN_CONT || ev) && !reading_busy_i) begin
        next_s.start = 1'b1;
      end
    end

    if (advanced_select_i) begin
      next_s.basic   = 1'b0;
      next_s.run     = panel_trigger_key_lock_pkg::RUN_IDLE;
      next_s.pending = 1'b0;
      next_s.start   = 1'b0;
    end else if (cmd_wr && wdata_i[`CMD_BASIC_BIT]) begin
      next_s.basic = 1'b1;
    end

    next_s.rdata = 32'h00000000;
    if (rd_i) begin
      case (addr_i)
        `ADDR_LOCK: next_s.rdata[`LOCK_FLAG_BIT] = s.lockout;
        `ADDR_PANEL_TRIGGER_KEY: next_s.rdata = {28'h0000000, s.single, s.src};
        `ADDR_IVL:  next_s.rdata = {5'h00, s.interval};
        `ADDR_STAT: next_s.rdata = {28'h0000000, (s.run == panel_trigger_key_lock_pkg::RUN_CONT),
                                    keys_ok, s.basic, s.host_ctrl};
        default:    next_s.rdata = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      s          <= '0;
      s.basic    <= 1'b1;
      s.interval <= `IVL_RESET;
    end else begin
      s <= next_s;
    end
  end

  assign tmr.restart        = s.restart;
  assign tmr.interval       = s.interval;
  assign rdata_o            = s.rdata;
  assign reading_start_o    = s.start;
  assign panel_keys_o       = s.keys;
  assign host_ctrl_o        = s.host_ctrl;
  assign key_lockout_flag_o = s.lockout;
  assign basic_active_o     = s.basic;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  keys_locked_a: assert property ((s.host_ctrl && s.lockout) |=>
    (panel_keys_o == '0))
    else $error("panel keys passed while locked in host control");

  lock_refused_a: assert property ((lock_wr && !(serial_port_i && s.host_ctrl)) |=>
    $stable(key_lockout_flag_o))
    else $error("lockout changed by a refused write");

  lock_taken_a: assert property ((lock_wr && serial_port_i && s.host_ctrl) |=>
    (key_lockout_flag_o == $past(lock_bit)))
    else $error("lockout write from serial port in host control lost");

  panel_keeps_a: assert property ((panel_cmd && !lock_wr) |=>
    (!host_ctrl_o && $stable(key_lockout_flag_o)))
    else $error("panel command did not free keys or altered lockout");

  basic_enter_a: assert property ((cmd_wr && wdata_i[`CMD_BASIC_BIT] &&
    !advanced_select_i) |=> basic_active_o)
    else $error("basic trigger command did not select basic triggering");

  repeat_run_a: assert property ((s.basic && !s.single && ev && !reading_busy_i &&
    !advanced_select_i && !panel_trigger_key_wr) |=> reading_start_o ##1
    (reading_start_o || $past(reading_busy_i) || (s.run != panel_trigger_key_lock_pkg::RUN_CONT)))
    else $error("repeat mode did not keep reading after an event");

  single_cause_a: assert property ((s.basic && s.single && !pend) |=>
    !reading_start_o)
    else $error("single mode read without an event");

  free_run_a: assert property ((s.basic && s.src == panel_trigger_key_lock_pkg::SRC_FREE &&
    !reading_busy_i && !advanced_select_i && !panel_trigger_key_wr) |=> reading_start_o)
    else $error("free-run did not start a reading");

  key_gate_a: assert property ((s.host_ctrl && s.src == panel_trigger_key_lock_pkg::SRC_KEY) |->
    !ev)
    else $error("trigger key fired in host control");

  timer_read_a: assert property ((tmr.expire && s.src == panel_trigger_key_lock_pkg::SRC_TIMER &&
    s.basic && s.single && !reading_busy_i && !advanced_select_i && !panel_trigger_key_wr) |=>
    reading_start_o)
    else $error("timer expiry did not trigger a reading");

  ivl_range_a: assert property ((s.interval >= `IVL_MIN) &&
    (s.interval <= `IVL_MAX))
    else $error("timer interval out of range");

  host_enter_a: assert property ((host_cmd && !panel_cmd) |=> host_ctrl_o)
    else $error("host command did not enter host control");

  bus_panel_trigger_key_a: assert property ((s.src == panel_trigger_key_lock_pkg::SRC_BUS && bus_get_i &&
    s.basic && s.single && !reading_busy_i && !advanced_select_i && !panel_trigger_key_wr) |=>
    reading_start_o)
    else $error("bus message did not start a reading");

  rear_panel_trigger_key_a: assert property ((s.src == panel_trigger_key_lock_pkg::SRC_REAR && rear_rise &&
    s.basic && s.single && !reading_busy_i && !advanced_select_i && !panel_trigger_key_wr) |=>
    reading_start_o)
    else $error("rear trigger edge did not start a reading");

  key_event_a: assert property ((s.src == panel_trigger_key_lock_pkg::SRC_KEY && key_rise &&
    s.basic && s.single && !reading_busy_i && !advanced_select_i && !panel_trigger_key_wr) |=>
    reading_start_o)
    else $error("panel trigger key did not start a reading");

  advanced_off_a: assert property (advanced_select_i |=>
    (!basic_active_o && !reading_start_o))
    else $error("advanced select left basic triggering running");

  timer_restart_a: assert property ((panel_trigger_key_wr && src_ok(new_src) &&
    (new_src == panel_trigger_key_lock_pkg::SRC_TIMER) && (s.src != panel_trigger_key_lock_pkg::SRC_TIMER)) |=>
    tmr.restart)
    else $error("timer not restarted on newly selecting it");

  lock_kept_a: assert property (!lock_wr |=> $stable(key_lockout_flag_o))
    else $error("lockout flag changed without a lockout write");

  single_read_c: cover property (s.single && reading_start_o);
  repeat_run_c:  cover property (s.run == panel_trigger_key_lock_pkg::RUN_CONT);
  locked_c:      cover property (s.host_ctrl && s.lockout);
  timer_fire_c:  cover property (tmr.expire && s.src == panel_trigger_key_lock_pkg::SRC_TIMER);

endmodule

// *** panel_trigger_key_lock_regs.svh ***
/*
  Register offsets, field positions, reset values and timing figures for the
  basic trigger and key lockout block.
  Assumes a 25 MHz system clock and a byte-addressed register port.
*/
`ifndef PANEL_TRIGGER_KEY_LOCK_REGS_SVH
`define PANEL_TRIGGER_KEY_LOCK_REGS_SVH

`define ADDR_W           8
`define ADDR_CMD         8'h00
`define ADDR_LOCK        8'h04
`define ADDR_PANEL_TRIGGER_KEY        8'h08
`define ADDR_IVL         8'h0c
`define ADDR_STAT        8'h10

`define CMD_HOST_BIT     0
`define CMD_PANEL_BIT    1
`define CMD_BASIC_BIT    2
`define CMD_BUSTRG_BIT   3

`define LOCK_FLAG_BIT    0
`define PANEL_TRIGGER_KEY_SRC_MSB     2
`define PANEL_TRIGGER_KEY_SRC_LSB     0
`define PANEL_TRIGGER_KEY_SINGLE_BIT  3

`define IVL_W            27
`define IVL_MIN          27'h0000001
`define IVL_MAX          27'h5f5e0ff
`define IVL_RESET        27'h0000064

`define KEYS_W           8
`define PRE_W            15

`define TIME_MS_NS       32'h000f4240
`define CLK_PERIOD_NS    32'h00000028

`endif

// *** panel_trigger_key_lock_pkg.sv ***
/*
  Types shared by the basic trigger and key lockout design.
  Assumes panel_trigger_key_lock_regs.svh is on the include path.
*/
`include "panel_trigger_key_lock_regs.svh"

package panel_trigger_key_lock_pkg;

  typedef enum logic [2:0] {
    SRC_FREE  = 3'h0,
    SRC_KEY   = 3'h1,
    SRC_BUS   = 3'h2,
    SRC_REAR  = 3'h3,
    SRC_TIMER = 3'h4
  } panel_trigger_key_src_e;

  typedef enum logic [1:0] {
    RUN_IDLE = 2'h0,
    RUN_CONT = 2'h1
  } run_e;

  typedef struct packed {
    logic                  host_ctrl;
    logic                  lockout;
    logic                  basic;
    logic                  single;
    panel_trigger_key_src_e             src;
    logic [`IVL_W-1:0]     interval;
    run_e                  run;
    logic                  pending;
    logic                  bus_trg;
    logic                  restart;
    logic                  start;
    logic [`KEYS_W+1:0]    sync1;
    logic [`KEYS_W+1:0]    sync2;
    logic [1:0]            prev;
    logic [`KEYS_W-1:0]    keys;
    logic [31:0]           rdata;
  } ctrl_state_s;

  typedef struct packed {
    logic [`PRE_W-1:0]     pre;
    logic [`IVL_W-1:0]     ms;
    logic                  expire;
  } timer_state_s;

endpackage

// *** timer_if.sv ***
/*
  Link between the trigger control and its millisecond interval timer.
  Assumes both ends run on the same clock.
*/
`timescale 1ns/10ps
`include "panel_trigger_key_lock_regs.svh"

interface timer_if;
  logic                  restart;
  logic [`IVL_W-1:0]     interval;
  logic                  expire;

  modport timer (input restart, input interval, output expire);
  modport ctrl  (output restart, output interval, input expire);
endinterface

// *** interval_timer.sv ***
/*
  Millisecond interval timer: pulses expire once per programmed interval.
  Assumes interval stays within 1..99999999 ms and restart is a clean pulse.
*/
`timescale 1ns/10ps
`include "panel_trigger_key_lock_regs.svh"

module interval_timer #(
  parameter int MS_CYCLES = 25000
) (
  input  wire logic clk_i,
  input  wire logic rst_n_i,
  timer_if.timer    tmr
);

  panel_trigger_key_lock_pkg::timer_state_s s;
  panel_trigger_key_lock_pkg::timer_state_s next_s;

  always_comb begin
    next_s        = s;
    next_s.expire = 1'b0;
    if (tmr.restart) begin
      next_s.pre = '0;
      next_s.ms  = '0;
    end else if (s.pre == `PRE_W'(MS_CYCLES - 1)) begin
      next_s.pre = '0;
      if (s.ms + `IVL_W'(1) >= tmr.interval) begin
        next_s.ms     = '0;
        next_s.expire = 1'b1;
      end else begin
        next_s.ms = s.ms + `IVL_W'(1);
      end
    end else begin
      next_s.pre = s.pre + `PRE_W'(1);
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign tmr.expire = s.expire;

  restart_quiet_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    tmr.restart |=> !tmr.expire)
    else $error("timer expired right after a restart");

endmodule

// *** host_model.sv ***
/*
  Host computer model: issues register commands to the trigger block.
  Assumes it shares the block's clock; the block never stalls it.
*/
`timescale 1ns/10ps
`include "panel_trigger_key_lock_regs.svh"

module host_model (
  input  wire logic               clk_i,
  input  wire logic [31:0]        rdata_i,
  output logic      [`ADDR_W-1:0] addr_o,
  output logic      [31:0]        wdata_o,
  output logic                    wr_o,
  output logic                    rd_o,
  output logic                    serial_o
);
  initial begin
    addr_o   = '0;
    wdata_o  = '0;
    wr_o     = 1'b0;
    rd_o     = 1'b0;
    serial_o = 1'b0;
  end

  // idle lines are inverted so a stale value can never pass for a real one
  task automatic write_reg(input logic [`ADDR_W-1:0] a, input logic [31:0] d,
                           input logic ser);
    @(posedge clk_i);
    addr_o   <= a;
    wdata_o  <= d;
    serial_o <= ser;
    wr_o     <= 1'b1;
    @(posedge clk_i);
    wr_o     <= 1'b0;
    addr_o   <= ~a;
    wdata_o  <= ~d;
  endtask

  task automatic read_reg(input logic [`ADDR_W-1:0] a, output logic [31:0] d);
    @(posedge clk_i);
    addr_o <= a;
    rd_o   <= 1'b1;
    @(posedge clk_i);
    rd_o   <= 1'b0;
    addr_o <= ~a;
    @(posedge clk_i);
    d = rdata_i;
  endtask

  // the flag is changed only after entering host control
  task automatic set_lockout(input logic f);
    write_reg(`ADDR_CMD, 32'h1, 1'b1);
    write_reg(`ADDR_LOCK, {31'h0, f}, 1'b1);
  endtask
endmodule

// *** tb.sv ***
/*
  Self-checking bench for the basic trigger and key lockout block.
  Assumes host_model drives the register port; MS_CYCLES is cut to 4.
*/
`timescale 1ns/10ps
`include "panel_trigger_key_lock_regs.svh"

module tb;
  logic               clk = 1'b0;
  logic               rst_n, bus_get, adv_sel, panel_trigger_key_key, rear_in, busy;
  logic [7:0]         keys_in, keys_out;
  logic [`ADDR_W-1:0] addr;
  logic [31:0]        wdata, rdata, d;
  logic               wr, rd, ser, start, host, lock_flag, basic;
  int                 bad_count = 0;
  int                 checks_done = 0;
  int                 starts = 0;
  int                 s0 = 0;
  int                 cycles = 0;

  always #20 clk = ~clk;

  host_model u_host_model (.clk_i(clk), .rdata_i(rdata), .addr_o(addr), .wdata_o(wdata),
                           .wr_o(wr), .rd_o(rd), .serial_o(ser));

  basic_trigger_and_key_lockout #(.MS_CYCLES(4)) u_basic_trigger_and_key_lockout (
    .clk_i(clk), .rst_n_i(rst_n), .addr_i(addr), .wdata_i(wdata), .wr_i(wr), .rd_i(rd),
    .serial_port_i(ser), .rdata_o(rdata), .bus_get_i(bus_get), .advanced_select_i(adv_sel),
    .panel_trigger_key_i(panel_trigger_key_key), .rear_trigger_input_i(rear_in), .panel_keys_i(keys_in),
    .reading_busy_i(busy), .reading_start_o(start), .panel_keys_o(keys_out),
    .host_ctrl_o(host), .key_lockout_flag_o(lock_flag), .basic_active_o(basic));

  always @(posedge clk) begin
    if (start === 1'b1)
      starts <= starts + 1;
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      bad_count++;
      $display("run timed out");
      complete_run();
    end
  end

  task automatic complete_run();
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic check(input string name, input logic [31:0] exp, input logic [31:0] seen);
    checks_done++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic mark();
    s0 = starts;
  endtask

  // readings started since the last mark
  task automatic got(input string name, input int exp);
    check(name, exp, starts - s0);
    mark();
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [31:0] v, input logic s);
    u_host_model.write_reg(a, v, s);
    tick(2);
  endtask

  task automatic pulse_get();
    bus_get <= 1'b1;
    tick(1);
    bus_get <= 1'b0;
    tick(1);
  endtask

  task automatic press_key();
    panel_trigger_key_key <= 1'b1;
    tick(4);
    panel_trigger_key_key <= 1'b0;
    tick(6);
  endtask

  initial begin
    rst_n    = 1'b0;
    bus_get  = 1'b0;
    adv_sel  = 1'b0;
    panel_trigger_key_key = 1'b0;
    rear_in  = 1'b0;
    busy     = 1'b0;
    keys_in  = 8'ha5;
    tick(10);
    rst_n <= 1'b1;
    tick(4);
    check("host", 0, host);
    check("lock", 0, lock_flag);
    check("keys", 8'ha5, keys_out);
    u_host_model.read_reg(`ADDR_IVL, d);
    check("interval", 32'h64, d);
    mark();
    tick(20);
    got("free-run", 20);
    $display("test reset done");

    wr_reg(`ADDR_LOCK, 32'h1, 1'b1);
    check("lock panel", 0, lock_flag);
    wr_reg(`ADDR_CMD, 32'h1, 1'b1);
    wr_reg(`ADDR_LOCK, 32'h1, 1'b0);
    check("host", 1, host);
    check("lock other port", 0, lock_flag);
    check("keys open", 8'ha5, keys_out);
    u_host_model.set_lockout(1'b1);
    tick(4);
    check("lock", 1, lock_flag);
    check("keys locked", 0, keys_out);
    u_host_model.read_reg(`ADDR_STAT, d);
    check("status", 32'h3, d & 32'h7);
    wr_reg(`ADDR_CMD, 32'h2, 1'b1);
    tick(2);
    check("host", 0, host);
    check("lock kept", 1, lock_flag);
    check("keys back", 8'ha5, keys_out);
    u_host_model.read_reg(8'h14, d);
    check("unmapped", 0, d);
    u_host_model.read_reg(`ADDR_CMD, d);
    check("cmd read", 0, d);
    $display("test lockout done");

    wr_reg(`ADDR_PANEL_TRIGGER_KEY, 32'ha, 1'b0);
    mark();
    tick(10);
    got("bus idle", 0);
    pulse_get();
    tick(4);
    got("bus get", 1);
    wr_reg(`ADDR_CMD, 32'h8, 1'b0);
    tick(4);
    got("bus cmd", 1);
    busy <= 1'b1;
    pulse_get();
    pulse_get();
    tick(4);
    got("busy hold", 0);
    busy <= 1'b0;
    tick(6);
    got("busy release", 1);
    wr_reg(`ADDR_PANEL_TRIGGER_KEY, 32'hb, 1'b0);
    mark();
    rear_in <= 1'b1;
    tick(4);
    rear_in <= 1'b0;
    tick(6);
    got("rear", 1);
    wr_reg(`ADDR_PANEL_TRIGGER_KEY, 32'h9, 1'b0);
    mark();
    press_key();
    got("key panel", 1);
    wr_reg(`ADDR_CMD, 32'h1, 1'b1);
    mark();
    press_key();
    got("key host", 0);
    wr_reg(`ADDR_CMD, 32'h2, 1'b1);
    $display("test single sources done");

    wr_reg(`ADDR_PANEL_TRIGGER_KEY, 32'hc, 1'b0);
    mark();
    tick(805);
    got("timer reset", 2);
    wr_reg(`ADDR_IVL, 32'h2, 1'b0);
    mark();
    tick(85);
    got("timer 2ms", 10);
    wr_reg(`ADDR_IVL, 32'h0, 1'b0);
    wr_reg(`ADDR_IVL, 32'h5f5e100, 1'b0);
    mark();
    tick(80);
    got("timer range", 10);
    $display("test timer done");

    wr_reg(`ADDR_PANEL_TRIGGER_KEY, 32'h2, 1'b0);
    mark();
    tick(10);
    got("repeat idle", 0);
    pulse_get();
    tick(2);
    mark();
    tick(20);
    got("repeat run", 20);
    adv_sel <= 1'b1;
    tick(1);
    adv_sel <= 1'b0;
    tick(3);
    check("basic off", 0, basic);
    mark();
    tick(10);
    got("advanced", 0);
    wr_reg(`ADDR_CMD, 32'h4, 1'b0);
    check("basic on", 1, basic);
    wr_reg(`ADDR_CMD, 32'h4, 1'b0);
    check("basic again", 1, basic);
    $display("test basic select done");
    complete_run();
  end
endmodule
